// ---- src/dtc_top.sv ----
`timescale 1ns/1ps

module dtc_top import dtc_pkg::*; #(
    parameter int unsigned ADDR_W = 8
) (
    input  wire logic              aclk,               // System clock, 10 MHz
    input  wire logic              aresetn,            // Sync reset, active low
    input  wire logic [ADDR_W-1:0] s_axi_awaddr,       // Write address
    input  wire logic              s_axi_awvalid,      // Write address valid
    output logic                   s_axi_awready,      // Write address ready
    input  wire logic [31:0]       s_axi_wdata,        // Write data
    input  wire logic [3:0]        s_axi_wstrb,        // Write strobes
    input  wire logic              s_axi_wvalid,       // Write data valid
    output logic                   s_axi_wready,       // Write data ready
    output logic [1:0]             s_axi_bresp,        // Write response
    output logic                   s_axi_bvalid,       // Write response valid
    input  wire logic              s_axi_bready,       // Write response ready
    input  wire logic [ADDR_W-1:0] s_axi_araddr,       // Read address
    input  wire logic              s_axi_arvalid,      // Read address valid
    output logic                   s_axi_arready,      // Read address ready
    output logic [31:0]            s_axi_rdata,        // Read data
    output logic [1:0]             s_axi_rresp,        // Read response
    output logic                   s_axi_rvalid,       // Read data valid
    input  wire logic              s_axi_rready,       // Read data ready
    input  wire logic              count_pin_zero,     // Timer 0 count pin
    input  wire logic              count_pin_one,      // Timer 1 count pin
    input  wire logic [1:0]        external_gate_pin,  // Gate pins, per timer
    input  wire logic [1:0]        irq_ack,            // Vectoring acknowledge
    output logic      [1:0]        timer_irq           // Interrupt requests
);

    // Pin synchronisers: {gate1, gate0, count1, count0}
    logic [3:0] pin_meta_reg;  // First stage
    logic [3:0] pin_sync_reg;  // Second stage

    // Machine cycle timing
    logic [1:0] phase_reg;   // Phase within machine cycle
    logic [1:0] mc_cnt_reg;  // Machine cycles for compatible rate

    // Software state
    logic [7:0] tmode_reg;  // timer_mode_register
    logic [1:0] run_reg;    // run_control bits
    logic [1:0] ovf_reg;    // overflow_flag bits
    logic [1:0] turbo_reg;  // Turbo select bits
    logic [1:0] ien_reg;    // Interrupt enables

    // Per timer decode
    dtc_tmode_type tm [2];           // Mode nibble per timer
    logic [1:0]    samp_reg;         // Last C4 pin sample
    logic [1:0]    edge_reg;         // Falling edge seen last C4
    logic [1:0]    tick;             // Machine clock tick
    logic [1:0]    enable;           // Run and gate allow counting
    logic [1:0]    cnt_event;        // Event to counter
    logic [1:0]    ovf_hit;          // Counter wraps now
    logic [1:0]    wr_low;           // Low byte write pulse
    logic [1:0]    wr_high;          // High byte write pulse
    logic [7:0]    cnt_low  [2];     // Low bytes
    logic [7:0]    cnt_high [2];     // High bytes

    // Bus slave state
    logic              aw_got_reg;    // Write address held
    logic              w_got_reg;     // Write data held
    logic [ADDR_W-1:0] awaddr_reg;    // Held write address
    logic [7:0]        wdata_reg;     // Held write byte
    logic              wstrb0_reg;    // Held lane 0 strobe
    logic              do_write;      // Commit write now
    logic              wr_hit;        // Write address mapped
    logic [7:0]        rd_byte;       // Read mux result
    logic              rd_hit;        // Read address mapped
    logic              wr_tmode;      // Mode register write
    logic              wr_timer_control_register;       // Control register write
    logic              wr_clock_control_register;      // Clock control write
    logic              wr_ien;        // Interrupt enable write

    // Two flops on every pin before use
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_meta_reg <= 4'h0;
            pin_sync_reg <= 4'h0;
        end else begin
            pin_meta_reg <= {external_gate_pin, count_pin_one, count_pin_zero};
            pin_sync_reg <= pin_meta_reg;
        end
    end

    // Machine cycle phase and compatible-rate divider
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            phase_reg  <= PH_C1;
            mc_cnt_reg <= RST_PAIR;
        end else begin
            phase_reg <= phase_reg + 2'h1;
            if (phase_reg == PH_C4) begin
                // Wrap after three machine cycles
                if (mc_cnt_reg == MC_PER_COMPAT_TICK - 2'h1) begin
                    mc_cnt_reg <= RST_PAIR;
                end else begin
                    mc_cnt_reg <= mc_cnt_reg + 2'h1;
                end
            end
        end
    end

    // Two independent timers
    generate
        for (genvar i = 0; i < 2; i++) begin : g_tmr
            // Mode nibble, function bit lands on bit 2 or 6
            assign tm[i] = tmode_reg[i*TIMER_MODE_REGISTER_T1_LSB +: TIMER_MODE_REGISTER_T1_LSB];

            // Every C3 in turbo, every third C3 otherwise
            assign tick[i] = (phase_reg == PH_C3)
                             && (turbo_reg[i] || mc_cnt_reg == RST_PAIR);

            // Run bit and gate pin
            assign enable[i] = run_reg[i]
                               && (!tm[i].gate || pin_sync_reg[2+i]);

            // Edge events counted at C3 of the following machine cycle
            assign cnt_event[i] = enable[i] && (tm[i].count_func
                                  ? (phase_reg == PH_C3 && edge_reg[i])
                                  : tick[i]);

            // Write pulses for this timer's bytes
            assign wr_low[i]  = do_write
                && awaddr_reg == ADDR_W'(i == 0 ? OFS_LOW0 : OFS_LOW1);
            assign wr_high[i] = do_write
                && awaddr_reg == ADDR_W'(i == 0 ? OFS_HIGH0 : OFS_HIGH1);

            // Pin sampled once a machine cycle at C4; slow sources assumed
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    samp_reg[i] <= 1'b0;
                    edge_reg[i] <= 1'b0;
                end else if (phase_reg == PH_C4) begin
                    samp_reg[i] <= pin_sync_reg[i];
                    edge_reg[i] <= samp_reg[i] && !pin_sync_reg[i];
                end
            end

            // Count register pair, mode field picks width
            dtc_counter #(
                .BYTE_W (8)
            ) u_cnt (
                .aclk            (aclk),
                .aresetn         (aresetn),
                .count_event     (cnt_event[i]),
                .mode13          ({tm[i].mode_field_high, tm[i].mode_field_low}
                                  == MODE_13BIT),
                .wr_low          (wr_low[i] && wstrb0_reg),
                .wr_high         (wr_high[i] && wstrb0_reg),
                .wdata           (wdata_reg),
                .count_low_byte  (cnt_low[i]),
                .count_high_byte (cnt_high[i]),
                .overflow_hit    (ovf_hit[i])
            );
        end
    endgenerate

    // Register write decode
    always_comb begin
        wr_tmode = do_write && wstrb0_reg && awaddr_reg == ADDR_W'(OFS_TIMER_MODE_REGISTER);
        wr_timer_control_register  = do_write && wstrb0_reg && awaddr_reg == ADDR_W'(OFS_TIMER_CONTROL_REGISTER);
        wr_clock_control_register = do_write && wstrb0_reg && awaddr_reg == ADDR_W'(OFS_CLOCK_CONTROL_REGISTER);
        wr_ien   = do_write && wstrb0_reg && awaddr_reg == ADDR_W'(OFS_IEN);
        wr_hit   = wr_tmode || wr_timer_control_register || wr_clock_control_register || wr_ien
                   || (|wr_low) || (|wr_high) || (do_write && !wstrb0_reg);
    end

    // Mode, run, turbo and enable registers
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            tmode_reg <= RST_BYTE;
            run_reg   <= RST_PAIR;
            turbo_reg <= RST_PAIR;
            ien_reg   <= RST_PAIR;
        end else begin
            if (wr_tmode) begin
                tmode_reg <= wdata_reg;
            end
            if (wr_timer_control_register) begin
                run_reg <= {wdata_reg[TIMER_CONTROL_REGISTER_RUN1], wdata_reg[TIMER_CONTROL_REGISTER_RUN0]};
            end
            if (wr_clock_control_register) begin
                turbo_reg <= {wdata_reg[CLOCK_CONTROL_REGISTER_TB1], wdata_reg[CLOCK_CONTROL_REGISTER_TB0]};
            end
            if (wr_ien) begin
                ien_reg <= wdata_reg[1:0];
            end
        end
    end

    // Overflow flags: hardware set beats any clear
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ovf_reg <= RST_PAIR;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (ovf_hit[i]) begin
                    ovf_reg[i] <= 1'b1;
                end else if (irq_ack[i]) begin
                    ovf_reg[i] <= 1'b0;
                end else if (wr_timer_control_register) begin
                    ovf_reg[i] <= wdata_reg[i == 0 ? TIMER_CONTROL_REGISTER_OVF0 : TIMER_CONTROL_REGISTER_OVF1];
                end
            end
        end
    end

    // Interrupt requests from flag and enable
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            timer_irq <= RST_PAIR;
        end else begin
            timer_irq <= ovf_reg & ien_reg;
        end
    end

    // Write channel capture, either order
    assign do_write = aw_got_reg && w_got_reg && !s_axi_bvalid;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_reg    <= 1'b0;
            s_axi_awready <= 1'b0;
            awaddr_reg    <= '0;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_got_reg    <= 1'b1;
            s_axi_awready <= 1'b0;
            awaddr_reg    <= s_axi_awaddr;
        end else begin
            if (do_write) begin
                aw_got_reg <= 1'b0;
            end
            // Ready again once idle
            s_axi_awready <= !aw_got_reg && !s_axi_bvalid;
        end
    end

    // Write data capture
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_got_reg    <= 1'b0;
            s_axi_wready <= 1'b0;
            wdata_reg    <= RST_BYTE;
            wstrb0_reg   <= 1'b0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_got_reg    <= 1'b1;
            s_axi_wready <= 1'b0;
            wdata_reg    <= s_axi_wdata[7:0];
            wstrb0_reg   <= s_axi_wstrb[0];
        end else begin
            if (do_write) begin
                w_got_reg <= 1'b0;
            end
            s_axi_wready <= !w_got_reg && !s_axi_bvalid;
        end
    end

    // Write response, error on unmapped address when lane 0 strobe is set
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp  <= RESP_OKAY;
        end else if (do_write) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= wr_hit ? RESP_OKAY : RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read mux over all registers
    always_comb begin
        rd_hit  = 1'b1;
        rd_byte = RST_BYTE;
        case (s_axi_araddr)
            ADDR_W'(OFS_LOW0):  rd_byte = cnt_low[0];
            ADDR_W'(OFS_HIGH0): rd_byte = cnt_high[0];
            ADDR_W'(OFS_LOW1):  rd_byte = cnt_low[1];
            ADDR_W'(OFS_HIGH1): rd_byte = cnt_high[1];
            ADDR_W'(OFS_TIMER_MODE_REGISTER):  rd_byte = tmode_reg;
            ADDR_W'(OFS_TIMER_CONTROL_REGISTER):  rd_byte = {ovf_reg[1], run_reg[1], ovf_reg[0],
                                           run_reg[0], 4'h0};
            ADDR_W'(OFS_CLOCK_CONTROL_REGISTER): rd_byte = {3'h0, turbo_reg, 3'h0};
            ADDR_W'(OFS_IEN):   rd_byte = {6'h00, ien_reg};
            default:            rd_hit  = 1'b0;
        endcase
    end

    // Read channel, data captured with the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b0;
            s_axi_rdata   <= 32'h0000_0000;
            s_axi_rresp   <= RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid  <= 1'b1;
            s_axi_rdata   <= {24'h00_0000, rd_byte};
            s_axi_rresp   <= rd_hit ? RESP_OKAY : RESP_SLVERR;
        end else begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
            end
            s_axi_arready <= !s_axi_rvalid;
        end
    end

    // Checks on timer 0
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    overflow_set_a: assert property (
        ovf_hit[0] |=> ovf_reg[0]) else $error("overflow flag not set");
    irq_follow_a: assert property (
        ovf_reg[0] && ien_reg[0] |=> timer_irq[0]) else $error("no interrupt request");
    flag_clear_a: assert property (
        irq_ack[0] && !ovf_hit[0] |=> !ovf_reg[0]) else $error("flag not cleared");
    flag_hold_a: assert property (
        ovf_reg[0] && !irq_ack[0] && !wr_timer_control_register |=> ovf_reg[0]) else $error("flag lost");
    run_gate_a: assert property (
        (!run_reg[0] || (tmode_reg[3] && !pin_sync_reg[2])) |-> !cnt_event[0])
        else $error("count while disabled");
    count_phase_a: assert property (
        cnt_event[0] |-> phase_reg == PH_C3) else $error("count off phase C3");
    turbo_rate_a: assert property (
        tick[0] && turbo_reg[0] |-> ##4 (tick[0] || !turbo_reg[0]))
        else $error("turbo tick not every 4 clocks");
    compat_rate_a: assert property (
        tick[0] && !turbo_reg[0] ##4 !turbo_reg[0] |-> !tick[0] ##8 (tick[0] || turbo_reg[0]))
        else $error("compatible tick not every 12 clocks");
    edge_detect_a: assert property (
        phase_reg == PH_C4 && samp_reg[0] && !pin_sync_reg[0] |=> edge_reg[0] [*4])
        else $error("falling edge missed");
    mode0_carry_a: assert property (
        cnt_event[0] && tmode_reg[1:0] == MODE_13BIT && &cnt_low[0][4:0] && !wr_high[0]
        |=> cnt_high[0] == $past(cnt_high[0]) + 8'h01) else $error("high byte not stepped");
    upper_kept_a: assert property (
        cnt_event[0] && tmode_reg[1:0] == MODE_13BIT && !wr_low[0]
        |=> cnt_low[0][7:5] == $past(cnt_low[0][7:5])) else $error("upper low bits moved");

    wrap_cov: cover property (ovf_hit[0] ##1 ovf_reg[0]);
    pin_count_cov: cover property (tmode_reg[2] && cnt_event[0]);
    irq_cov: cover property (timer_irq[0] ##1 irq_ack[0]);
    gated_cov: cover property (run_reg[0] && tmode_reg[3] && !pin_sync_reg[2] && tick[0]);

endmodule

// ---- inc/dtc_pkg.sv ----
package dtc_pkg;

    // Machine cycle phases, four clocks per machine cycle
    localparam logic [1:0] PH_C1 = 2'h0;
    localparam logic [1:0] PH_C3 = 2'h2;
    localparam logic [1:0] PH_C4 = 2'h3;

    // Machine cycles per tick at the compatible divide-by-twelve rate
    localparam logic [1:0] MC_PER_COMPAT_TICK = 2'h3;

    // Byte addresses of the registers
    localparam logic [7:0] OFS_LOW0  = 8'h00;  // count_low_byte, timer 0
    localparam logic [7:0] OFS_HIGH0 = 8'h04;  // count_high_byte, timer 0
    localparam logic [7:0] OFS_LOW1  = 8'h08;  // count_low_byte, timer 1
    localparam logic [7:0] OFS_HIGH1 = 8'h0c;  // count_high_byte, timer 1
    localparam logic [7:0] OFS_TIMER_MODE_REGISTER  = 8'h10;  // timer_mode_register
    localparam logic [7:0] OFS_TIMER_CONTROL_REGISTER  = 8'h14;  // timer_control_register
    localparam logic [7:0] OFS_CLOCK_CONTROL_REGISTER = 8'h18;  // clock_control_register
    localparam logic [7:0] OFS_IEN   = 8'h1c;  // interrupt enable register

    // Field positions
    localparam int unsigned TIMER_MODE_REGISTER_T1_LSB = 4;  // Timer 1 nibble of mode register
    localparam int unsigned TIMER_MODE_REGISTER_FUNC0  = 2;  // Function select, timer 0
    localparam int unsigned TIMER_MODE_REGISTER_FUNC1  = 6;  // Function select, timer 1
    localparam int unsigned TIMER_CONTROL_REGISTER_RUN0   = 4;  // run_control, timer 0
    localparam int unsigned TIMER_CONTROL_REGISTER_OVF0   = 5;  // overflow_flag, timer 0
    localparam int unsigned TIMER_CONTROL_REGISTER_RUN1   = 6;  // run_control, timer 1
    localparam int unsigned TIMER_CONTROL_REGISTER_OVF1   = 7;  // overflow_flag, timer 1
    localparam int unsigned CLOCK_CONTROL_REGISTER_TB0   = 3;  // timer0_turbo_select
    localparam int unsigned CLOCK_CONTROL_REGISTER_TB1   = 4;  // timer1_turbo_select

    // Reset values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [1:0] RST_PAIR = 2'h0;

    // Mode 0 prescale width inside the low byte
    localparam int unsigned PRESCALE_W = 5;
    localparam logic [1:0]  MODE_13BIT = 2'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // One timer nibble of the mode register
    typedef struct packed {
        logic       gate;             // Gate counting by external_gate_pin
        logic       count_func;       // 1 counts pin edges, 0 machine clocks
        logic       mode_field_high;  // Mode select high bit
        logic       mode_field_low;   // Mode select low bit
    } dtc_tmode_type;

endpackage

// ---- src/dtc_counter.sv ----
`timescale 1ns/1ps

// One count register pair with mode 0 prescale and overflow detect
module dtc_counter import dtc_pkg::*; #(
    parameter int unsigned BYTE_W = 8
) (
    input  wire logic              aclk,             // System clock
    input  wire logic              aresetn,          // Sync reset, active low
    input  wire logic              count_event,      // One counted event
    input  wire logic              mode13,           // 13-bit mode selected
    input  wire logic              wr_low,           // Software writes low byte
    input  wire logic              wr_high,          // Software writes high byte
    input  wire logic [BYTE_W-1:0] wdata,            // Write data
    output logic      [BYTE_W-1:0] count_low_byte,   // Low byte
    output logic      [BYTE_W-1:0] count_high_byte,  // High byte
    output logic                   overflow_hit      // Count rolls over now
);

    localparam logic [BYTE_W-1:0]     ONE_B = 1;  // Byte increment
    localparam logic [PRESCALE_W-1:0] ONE_P = 1;  // Prescale increment

    logic low_carry;  // Low part about to wrap

    // Carry out of the low part, 5 or 8 bits wide
    always_comb begin
        if (mode13) begin
            low_carry = &count_low_byte[PRESCALE_W-1:0];
        end else begin
            low_carry = &count_low_byte;
        end
        overflow_hit = count_event && !wr_high && low_carry
                       && (&count_high_byte);
    end

    // Low byte, write wins over counting
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_low_byte <= RST_BYTE;
        end else if (wr_low) begin
            count_low_byte <= wdata;
        end else if (count_event && mode13) begin
            // Upper three bits left untouched
            count_low_byte[PRESCALE_W-1:0] <=
                count_low_byte[PRESCALE_W-1:0] + ONE_P;
        end else if (count_event) begin
            count_low_byte <= count_low_byte + ONE_B;
        end
    end

    // High byte steps on each carry out of the low part
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            count_high_byte <= RST_BYTE;
        end else if (wr_high) begin
            count_high_byte <= wdata;
        end else if (count_event && low_carry) begin
            count_high_byte <= count_high_byte + ONE_B;
        end
    end

endmodule

// ---- verif/dtc_pins_model.sv ----
`timescale 1ns/1ps

// Far side: count pins idle high, gate pins follow the bench
module dtc_pins_model #(
    parameter int unsigned EDGES = 3,  // Falling edges per burst
    parameter int unsigned HALF  = 16  // Clocks per pin level
) (
    input  wire logic       aclk,              // System clock
    input  wire logic [1:0] gate_req,          // Requested gate levels
    input  wire logic       burst,             // Start a burst of edges
    output logic            count_pin_zero,    // Timer 0 count pin
    output logic            count_pin_one,     // Timer 1 count pin
    output logic [1:0]      external_gate_pin  // Gate pins
);
    // Gate pins are plain levels from the bench
    assign external_gate_pin = gate_req;
    assign count_pin_zero    = count_pin_one;
    initial count_pin_one = 1'b1;
    // Edges at least 32 clocks apart keep the 1/8 limit
    always @(posedge aclk) begin
        if (burst) begin
            repeat (EDGES) begin
                repeat (HALF) @(posedge aclk);
                count_pin_one <= 1'b0;
                repeat (HALF) @(posedge aclk);
                count_pin_one <= 1'b1;
            end
        end
    end
endmodule

// ---- verif/dtc_top_tb.sv ----
`timescale 1ns/1ps

module dtc_top_tb import dtc_pkg::*;;
    logic        aclk, aresetn, pin0, pin1, burst;           // Clock, reset, pins
    logic [7:0]  awaddr, araddr;                             // Bus addresses
    logic [31:0] wdata, rdata;                               // Bus data
    logic        awvalid, awready, wvalid, wready, bvalid;   // Write side
    logic        bready, arvalid, arready, rvalid, rready;   // Read side
    logic [1:0]  bresp, rresp, gate_req, gate, irq_ack, irq; // Misc
    logic [33:0] q[$];                                       // Expected responses
    logic [7:0]  r[4];                                       // Random bytes
    int          miscompares, tests_run;                     // Counters

    dtc_top uut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'h1), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready), .count_pin_zero(pin0), .count_pin_one(pin1),
        .external_gate_pin(gate), .irq_ack(irq_ack), .timer_irq(irq));
    dtc_pins_model pins (.aclk(aclk), .gate_req(gate_req), .burst(burst),
        .count_pin_zero(pin0), .count_pin_one(pin1), .external_gate_pin(gate));

    // Clock
    initial begin
        aclk = 1'b0;
        forever #50 aclk = ~aclk;
    end

    // Compare and count
    task automatic check(input logic [33:0] seen, input logic [33:0] exp);
        tests_run++;
        if (seen !== exp) begin
            miscompares++;
            $display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tally_and_finish();
        $display("compares %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    // One write, response noted for the monitor
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] rs);
        q.push_back({rs, 32'h0});
        awaddr  <= a;
        wdata   <= {24'h0, d};
        awvalid <= 1'b1;
        wvalid  <= 1'b1;
        bready  <= 1'b1;
        // Body first: the request above only lands after this time step
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) bready <= 1'b0;
        end while (awvalid || wvalid || bready);
    endtask

    // One read, data noted for the monitor
    task automatic rd(input logic [7:0] a, input logic [7:0] d);
        q.push_back({RESP_OKAY, 24'h0, d});
        araddr  <= a;
        arvalid <= 1'b1;
        rready  <= 1'b1;
        // Body first: the request above only lands after this time step
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) rready <= 1'b0;
        end while (arvalid || rready);
    endtask

    // Open the gate of timer 0 for n clocks
    task automatic gate_for(input int n);
        gate_req <= 2'h1;
        repeat (n) @(posedge aclk);
        gate_req <= 2'h0;
        repeat (8) @(posedge aclk);
    endtask

    // Monitor: oldest note against each response
    always @(posedge aclk) begin
        if (bvalid && bready) check({bresp, 32'h0}, q.pop_front());
        if (rvalid && rready) check({rresp, rdata}, q.pop_front());
    end

    // Watchdog
    initial begin
        repeat (20000) @(posedge aclk);
        miscompares++;
        tally_and_finish();
    end

    // Main sequence
    initial begin
        {aresetn, awvalid, wvalid, bready, arvalid, rready, burst} = '0;
        {awaddr, araddr, wdata, gate_req, irq_ack} = '0;
        miscompares = 0;
        tests_run = 0;
        void'($urandom(27619));
        foreach (r[i]) r[i] = 8'($urandom);
        repeat (12) @(posedge aclk);
        aresetn <= 1'b1;
        @(posedge aclk);
        for (int i = 0; i < 8; i++) rd(8'(i * 4), RST_BYTE);
        foreach (r[i]) wr(8'(i * 4), r[i], RESP_OKAY);
        foreach (r[i]) rd(8'(i * 4), r[i]);
        wr(8'h20, r[0], RESP_SLVERR);
        wr(OFS_TIMER_MODE_REGISTER, 8'h48, RESP_OKAY);
        wr(OFS_CLOCK_CONTROL_REGISTER, 8'h08, RESP_OKAY);
        wr(OFS_LOW0, 8'hff, RESP_OKAY);  // Upper three bits set, must survive
        wr(OFS_HIGH0, 8'hff, RESP_OKAY);
        wr(OFS_LOW1, 8'h00, RESP_OKAY);
        wr(OFS_HIGH1, 8'h00, RESP_OKAY);
        wr(OFS_IEN, 8'h01, RESP_OKAY);
        wr(OFS_TIMER_CONTROL_REGISTER, 8'h50, RESP_OKAY);
        repeat (40) @(posedge aclk);
        rd(OFS_LOW0, 8'hff);
        gate_for(8);
        rd(OFS_LOW0, 8'he1);
        rd(OFS_HIGH0, 8'h00);
        rd(OFS_TIMER_CONTROL_REGISTER, 8'h70);
        check({32'h0, irq}, 34'h1);
        irq_ack <= 2'h1;
        @(posedge aclk);
        irq_ack <= 2'h0;
        repeat (3) @(posedge aclk);
        check({32'h0, irq}, 34'h0);
        rd(OFS_TIMER_CONTROL_REGISTER, 8'h50);
        wr(OFS_CLOCK_CONTROL_REGISTER, 8'h00, RESP_OKAY);
        gate_for(24);
        rd(OFS_LOW0, 8'he3);
        wr(OFS_TIMER_MODE_REGISTER, 8'h44, RESP_OKAY);
        burst <= 1'b1;
        @(posedge aclk);
        burst <= 1'b0;
        repeat (120) @(posedge aclk);
        rd(OFS_LOW1, 8'h03);
        rd(OFS_LOW0, 8'he6);
        tally_and_finish();
    end
endmodule
